// ### logic/timer16_pfc_consts.vh
// constants for the dual-slope pwm timer block
`ifndef TIMER16_PFC_CONSTS_VH
`define TIMER16_PFC_CONSTS_VH
// register addresses
`define CTLA_ADDR 8'h80
`define CTLB_ADDR 8'h81
`define CNT_ADDR 8'h84
`define CAP_ADDR 8'h86
`define CMPA_ADDR 8'h88
`define CMPB_ADDR 8'h8a
`define FLAG_ADDR 8'h8c
`define DDR_ADDR 8'h8d
// reset values
`define CTLA_RST 8'h00
`define CTLB_RST 5'h00
`define WORD_RST 16'h0000
`define FLAG_RST 4'h0
`define DDR_RST 2'h0
`define OUT_RST 2'h0
// control a fields
`define COMA_HI 7
`define COMA_LO 6
`define COMB_HI 5
`define COMB_LO 4
`define WGML_HI 1
`define WGML_LO 0
`define RSVD_ZERO 2'h0
// direction fields
`define DDR_HI 1
`define DDR_LO 0
// control b fields
`define WGMH_HI 1
`define WGMH_LO 0
`define PSEL_HI 4
`define PSEL_LO 2
// waveform modes
`define WGM_PFC_CAP 4'h8
`define WGM_PFC_CMPA 4'h9
`define WGM_PC_CMPA 4'hb
// compare output modes
`define COM_OFF 2'h0
`define COM_TOGGLE 2'h1
`define COM_NONINV 2'h2
`define COM_INV 2'h3
// prescale selects
`define PS_STOP 3'h0
`define PS_DIV1 3'h1
`define PS_DIV8 3'h2
`define PS_DIV64 3'h3
`define PS_DIV256 3'h4
`define PS_DIV1024 3'h5
// prescale terminal masks
`define PS_MASK8 10'h007
`define PS_MASK64 10'h03f
`define PS_MASK256 10'h0ff
`define PS_MASK1024 10'h3ff
`define PS_ZERO 10'h000
// flag bit positions
`define FLG_OVF 0
`define FLG_CMPA 1
`define FLG_CMPB 2
`define FLG_CAP 3
// counting limits
`define BOTTOM 16'h0000
`define MIN_TOP 16'h0003
`define ONE16 16'h0001
`endif

// ### logic/timer16_pfc_pwm.v
// dual-slope phase and frequency correct pwm timer with two compare channels
//
// Summary of operation
// - modes 0x8 and 0x9 select this operation
// - count zero up to top, back down
// - top from capture (0x8) or compare a (0x9)
// - counter holds top one tick, then reverses
// - non-inverting clears on up, sets on down
// - output mode 0x2 non-inverted, 0x3 inverted
// - active compares reload only at bottom
// - overflow flag set in reload tick
// - top source flag set on reaching top
// - match flag set when counter equals compare
// - top accepted from 0x0003 to 0xffff
// - top below compare gives no match
// - pin driven only when direction bit set
// - non-inverting: bottom compare stays low, top stays high
// - mode 0x9 with 0x1 toggles output a
// - tick divides clock by 1,8,64,256,1024
// - tick is a clock enable, one clock
// - control a resets zero, fixed field layout
// - mode 0x1 toggles a only for 9/11
// - output mode 0x2 or 0x3 overrides port function
`timescale 1ns/1ns
`default_nettype none
`include "timer16_pfc_consts.vh"

module timer16_pfc_pwm #(
  parameter CNT_W  = 16,
  parameter ADDR_W = 8
) (
  input  wire              mclk_in,
  input  wire              rst_in,
  input  wire [ADDR_W-1:0] addr_in,
  input  wire [CNT_W-1:0]  wdata_in,
  input  wire              wr_in,
  input  wire              rd_in,
  output wire [CNT_W-1:0]  rdata_out,
  input  wire              port_a_in,
  input  wire              port_b_in,
  output wire              pin_a_out,
  output wire              pin_a_oe_out,
  output wire              pin_b_out,
  output wire              pin_b_oe_out,
  output wire              timer_tick_out,
  output wire [3:0]        flags_out
);

  ////////////////////////////////////////////////////////////////////
  // register map, every register one sixteen-bit word on the bus
  //   control a    output modes of a and b, low mode bits
  //   control b    high mode bits and prescale select
  //   counter      running count; a write beats counting
  //   capture      top source of the capture-based mode
  //   compare a/b  buffered compare values, read back from the buffer
  //   flags        sticky events; writing one clears
  //   direction    output enables of pins a and b
  // bus behaviour
  //   read data stand one cycle after the strobe, zero otherwise
  //   unmapped addresses ignore writes and read zero
  // hazards for software
  //   a top below three is not refused; the count still folds
  //   a compare above top never matches, so its flag stays clear
  //   outside this mode the counter holds and actives follow buffers

  ////////////////////////////////////////////////////////////////////
  // direction states
  localparam [1:0] ST_UP = 2'b01;   // counting upward
  localparam [1:0] ST_DN = 2'b10;   // counting downward

  ////////////////////////////////////////////////////////////////////
  // storage
  // all state but dir_q (reset to ST_UP) resets to zero, so the block wakes stopped and disconnected
  reg [7:0]       timer1_control_a_q;  // output modes and low mode bits
  reg [4:0]       control_b_q;         // high mode bits and prescale
  reg [CNT_W-1:0] counter_value_q;     // running count
  reg [CNT_W-1:0] counter_value_d;     // next count
  reg [CNT_W-1:0] capture_value_q;     // top source in mode 0x8
  reg [CNT_W-1:0] buf_a_q;             // software side of compare a
  reg [CNT_W-1:0] buf_b_q;             // software side of compare b
  reg [CNT_W-1:0] act_a_q;             // compare a in use
  reg [CNT_W-1:0] act_b_q;             // compare b in use
  reg [3:0]       flag_q;              // sticky event flags
  reg [1:0]       output_pin_direction_q; // pin output enables
  reg [1:0]       dir_q;               // count direction state
  reg [1:0]       dir_d;               // next direction
  reg [1:0]       compare_output_q;    // waveform levels, b and a
  reg [9:0]       ps_q;                // prescale counter
  reg [CNT_W-1:0] rdata_q;             // registered read data
  reg [CNT_W-1:0] rd_mux;              // read selection
  reg             timer_tick;          // prescaled clock enable

  ////////////////////////////////////////////////////////////////////
  // decoded control
  wire [3:0] waveform_mode_select;     // full four-bit mode
  wire [1:0] com_a;                    // channel a output mode
  wire [1:0] com_b;                    // channel b output mode
  wire [2:0] psel;                     // prescale select
  wire       pfc_mode;                 // this block's mode active
  wire [CNT_W-1:0] top;                // current turning point
  wire       at_bottom;                // counter at zero
  wire       at_top;                   // counter at or past top
  wire       down_phase;               // match counts as down slope
  wire       reload;                   // bottom reload event
  wire       match_a;                  // compare a hit this tick
  wire       match_b;                  // compare b hit this tick
  wire       top_hit;                  // counter reached top this tick
  wire       toggle_ok;                // toggle allowed on channel a
  wire       conn_a;                   // channel a drives its pin
  wire       conn_b;                   // channel b drives its pin
  wire [3:0] flag_set;                 // hardware flag sets
  wire [3:0] flag_clr;                 // software flag clears

  assign com_a = timer1_control_a_q[`COMA_HI:`COMA_LO];
  assign com_b = timer1_control_a_q[`COMB_HI:`COMB_LO];
  assign psel  = control_b_q[`PSEL_HI:`PSEL_LO];
  // the mode field is split across the two control registers
  assign waveform_mode_select = {control_b_q[`WGMH_HI:`WGMH_LO],
                                 timer1_control_a_q[`WGML_HI:`WGML_LO]};

  // mode decode
  assign pfc_mode = (waveform_mode_select == `WGM_PFC_CAP) ||
                    (waveform_mode_select == `WGM_PFC_CMPA);

  // top source; any value from the minimum up to full range works
  // with compare a as top, top itself moves only at bottom
  assign top = (waveform_mode_select == `WGM_PFC_CMPA) ?
               act_a_q : capture_value_q;

  assign at_bottom = (counter_value_q == `BOTTOM);
  // at or past top, so a top lowered under the count still folds
  assign at_top    = (counter_value_q >= top);

  // bottom is the start of an up slope, top the start of a down slope
  assign down_phase = !at_bottom && (at_top || (dir_q == ST_DN));

  ////////////////////////////////////////////////////////////////////
  // prescaler: free counter, tick on terminal pattern
  // the divider runs whenever a select other than stop is set;
  // changing the select mid-count only moves the first tick
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ps_q <= `PS_ZERO;
    end else if (psel == `PS_STOP) begin
      ps_q <= `PS_ZERO;  // stopped: hold divider cleared
    end else begin
      ps_q <= ps_q + 10'h001;
    end
  end

  // tick selection acts as an enable, never as a clock
  always @* begin
    case (psel)
      `PS_DIV1:    timer_tick = 1'b1;
      `PS_DIV8:    timer_tick = ((ps_q & `PS_MASK8) == `PS_MASK8);
      `PS_DIV64:   timer_tick = ((ps_q & `PS_MASK64) == `PS_MASK64);
      `PS_DIV256:  timer_tick = ((ps_q & `PS_MASK256) == `PS_MASK256);
      `PS_DIV1024: timer_tick = (ps_q == `PS_MASK1024);
      default:     timer_tick = 1'b0;  // stopped or unused select
    endcase
  end

  assign timer_tick_out = timer_tick;

  ////////////////////////////////////////////////////////////////////
  // events of this tick
  // every event needs the tick, so a stopped prescaler sets no flag
  assign reload  = pfc_mode && timer_tick && at_bottom;
  // a compare above top is never reached, so it never matches
  assign match_a = pfc_mode && timer_tick &&
                   (counter_value_q == act_a_q);
  assign match_b = pfc_mode && timer_tick &&
                   (counter_value_q == act_b_q);
  assign top_hit = pfc_mode && timer_tick &&
                   (counter_value_q == top);

  ////////////////////////////////////////////////////////////////////
  // dual-slope sequencer
  always @* begin
    counter_value_d = counter_value_q;
    dir_d           = dir_q;
    case (dir_q)
      ST_UP: begin
        if (at_top) begin
          // top was shown for this one tick; step back down
          counter_value_d = counter_value_q - `ONE16;
          dir_d           = ST_DN;
        end else begin
          counter_value_d = counter_value_q + `ONE16;
        end
      end
      // bottom is shown for one tick too, then the climb resumes
      ST_DN: begin
        if (at_bottom) begin
          counter_value_d = counter_value_q + `ONE16;
          dir_d           = ST_UP;
        end else begin
          counter_value_d = counter_value_q - `ONE16;
        end
      end
      default: begin
        // a state that lost its one-hot bit restarts from bottom
        counter_value_d = `BOTTOM;  // recover from a bad state
        dir_d           = ST_UP;
      end
    endcase
  end

  // counter register: software write wins over counting
  // a write leaves the direction alone; a zero written while falling
  // turns the count upward at the next tick
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      counter_value_q <= `WORD_RST;
      dir_q           <= ST_UP;
    end else if (wr_in && (addr_in == `CNT_ADDR)) begin
      counter_value_q <= wdata_in;
    end else if (pfc_mode && timer_tick) begin
      counter_value_q <= counter_value_d;
      dir_q           <= dir_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control, capture and direction registers
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      timer1_control_a_q     <= `CTLA_RST;
      control_b_q            <= `CTLB_RST;
      capture_value_q        <= `WORD_RST;
      output_pin_direction_q <= `DDR_RST;
    end else if (wr_in) begin
      case (addr_in)
        // bits 3:2 of control a are not stored and read back zero
        `CTLA_ADDR: timer1_control_a_q <= {wdata_in[`COMA_HI:`COMB_LO], `RSVD_ZERO,
                                           wdata_in[`WGML_HI:`WGML_LO]};
        `CTLB_ADDR: control_b_q <= wdata_in[`PSEL_HI:`WGMH_LO];
        `CAP_ADDR:  capture_value_q <= wdata_in;
        `DDR_ADDR:  output_pin_direction_q <= wdata_in[`DDR_HI:`DDR_LO];
        default:    control_b_q <= control_b_q;  // other writes
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // double-buffered compares
  // reload and overflow share one event, so each period opens with fresh compares
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      buf_a_q <= `WORD_RST;
      buf_b_q <= `WORD_RST;
      act_a_q <= `WORD_RST;
      act_b_q <= `WORD_RST;
    end else begin
      // software lands in the buffer only
      if (wr_in && (addr_in == `CMPA_ADDR)) begin
        buf_a_q <= wdata_in;
      end
      if (wr_in && (addr_in == `CMPB_ADDR)) begin
        buf_b_q <= wdata_in;
      end
      if (reload) begin
        // copy at bottom keeps both slopes equal
        act_a_q <= buf_a_q;
        act_b_q <= buf_b_q;
      end else if (!pfc_mode) begin
        act_a_q <= buf_a_q;  // outside this mode: follow at once
        act_b_q <= buf_b_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sticky flags: write one to clear, a set in the same cycle wins
  // a clear and a set in one cycle leave the flag set, so no event is lost
  assign flag_set[`FLG_OVF]  = reload;
  assign flag_set[`FLG_CMPA] = match_a;
  assign flag_set[`FLG_CMPB] = match_b;
  assign flag_set[`FLG_CAP]  = top_hit &&
                               (waveform_mode_select == `WGM_PFC_CAP);
  assign flag_clr = (wr_in && (addr_in == `FLAG_ADDR)) ?
                    wdata_in[`FLG_CAP:`FLG_OVF] : 4'h0;

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_q <= `FLAG_RST;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  assign flags_out = flag_q;

  ////////////////////////////////////////////////////////////////////
  // waveform generators
  // levels change on the edge after the match tick, one tick behind the count
  // a compare equal to top matches only on the fold, which counts as falling
  assign toggle_ok = (waveform_mode_select == `WGM_PFC_CMPA) ||
                     (waveform_mode_select == `WGM_PC_CMPA);

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      compare_output_q <= `OUT_RST;
    end else begin
      // channel a
      if (match_a) begin
        case (com_a)
          // bottom match is up-slope, top match down-slope
          `COM_NONINV: compare_output_q[0] <= down_phase;
          `COM_INV:    compare_output_q[0] <= !down_phase;
          `COM_TOGGLE: begin
            if (toggle_ok) begin
              compare_output_q[0] <= !compare_output_q[0];
            end
          end
          default:     compare_output_q[0] <= compare_output_q[0];
        endcase
      end
      // channel b never toggles
      if (match_b) begin
        case (com_b)
          `COM_NONINV: compare_output_q[1] <= down_phase;
          `COM_INV:    compare_output_q[1] <= !down_phase;
          default:     compare_output_q[1] <= compare_output_q[1];
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin muxing
  // the enable comes from the direction bits alone; an undriven pin still shows the mux
  // pwm modes take the pin; 0x1 only for channel a in toggle modes
  assign conn_a = com_a[1] ||
                  ((com_a == `COM_TOGGLE) && toggle_ok);
  assign conn_b = com_b[1];

  assign pin_a_out    = conn_a ? compare_output_q[0] : port_a_in;
  assign pin_b_out    = conn_b ? compare_output_q[1] : port_b_in;
  assign pin_a_oe_out = output_pin_direction_q[0];
  assign pin_b_oe_out = output_pin_direction_q[1];

  ////////////////////////////////////////////////////////////////////
  // register reads, data valid the cycle after the strobe
  // reads have no side effects; flags clear only by a write
  always @* begin
    case (addr_in)
      `CTLA_ADDR: rd_mux = {8'h00, timer1_control_a_q};
      `CTLB_ADDR: rd_mux = {11'h000, control_b_q};
      `CNT_ADDR:  rd_mux = counter_value_q;
      `CAP_ADDR:  rd_mux = capture_value_q;
      `CMPA_ADDR: rd_mux = buf_a_q;
      `CMPB_ADDR: rd_mux = buf_b_q;
      `FLAG_ADDR: rd_mux = {12'h000, flag_q};
      `DDR_ADDR:  rd_mux = {14'h0000, output_pin_direction_q};
      default:    rd_mux = `WORD_RST;  // unmapped reads zero
    endcase
  end

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= `WORD_RST;
    end else if (rd_in) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= `WORD_RST;  // data stands one cycle only
    end
  end

  assign rdata_out = rdata_q;

endmodule
`default_nettype wire

// ### tb/timer16_pfc_chk.sv
// port-level assertions for the dual-slope pwm timer
`timescale 1ns/1ns
`default_nettype none
module timer16_pfc_chk (
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic        port_a_in,
  input wire logic        port_b_in,
  input wire logic        pin_a_out,
  input wire logic        pin_a_oe_out,
  input wire logic        pin_b_out,
  input wire logic        pin_b_oe_out,
  input wire logic        timer_tick_out,
  input wire logic [3:0]  flags_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // write strobes aimed at the direction and flag registers
  wire       dir_wr = wr_in && addr_in == 8'h8d;
  wire       flg_wr = wr_in && addr_in == 8'h8c;
  // flags that no write-one-to-clear touches this cycle
  wire [3:0] keep   = flags_out & ~(flg_wr ? wdata_in[3:0] : 4'h0);
  ////////////////////////////////////////////////////////////////////////
  property p_rd_idle; !rd_in |=> rdata_out == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_ctl_rsvd; rd_in && addr_in == 8'h80 |=> rdata_out[15:8] == 8'h00
    && rdata_out[3:2] == 2'h0; endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("unused control bits set");
  property p_unmapped; rd_in && addr_in == 8'h90 |=> rdata_out == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_oe_wr; dir_wr |=> {pin_b_oe_out, pin_a_oe_out} == $past(wdata_in[1:0]);
  endproperty
  a_oe_wr: assert property (p_oe_wr) else $error("enable not from direction write");
  property p_oe_hold; !dir_wr |=> $stable({pin_b_oe_out, pin_a_oe_out}); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("enable moved without write");
  property p_flag_hold; keep != 4'h0 |=> (flags_out & $past(keep)) == $past(keep);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
  property p_flag_tick; !timer_tick_out |=> (flags_out & ~$past(flags_out)) == 4'h0;
  endproperty
  a_flag_tick: assert property (p_flag_tick) else $error("flag set without tick");
  property p_flag_clr; flg_wr && wdata_in[3:0] == 4'hf && !timer_tick_out |=>
    flags_out == 4'h0; endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flags not cleared");
endmodule
bind timer16_pfc_pwm timer16_pfc_chk u_chk (.mclk_in(mclk_in), .rst_in(rst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .port_a_in(port_a_in), .port_b_in(port_b_in),
  .pin_a_out(pin_a_out), .pin_a_oe_out(pin_a_oe_out), .pin_b_out(pin_b_out),
  .pin_b_oe_out(pin_b_oe_out), .timer_tick_out(timer_tick_out), .flags_out(flags_out));
`default_nettype wire

// ### tb/pwm_load.sv
// external load on one compare output pin, counting cycles it sees high
`timescale 1ns/1ns
`default_nettype none
module pwm_load (
  input  wire logic        clk_in,
  input  wire logic        pin_in,
  input  wire logic        oe_in,
  input  wire logic        clr_in,
  output var  logic [15:0] high_cnt_out
);
  // a pull-down holds the line low while the pin is not driven
  wire level = oe_in & pin_in;
  // count high cycles, cleared on request
  always @(posedge clk_in) begin
    if (clr_in) high_cnt_out <= 16'h0000;
    else if (level) high_cnt_out <= high_cnt_out + 16'h0001;
  end
endmodule
`default_nettype wire

// ### tb/test_timer16_pfc_pwm.sv
// self-checking bench for the dual-slope pwm timer
`timescale 1ns/1ns
`default_nettype none
module test_timer16_pfc_pwm;
  logic        mclk_in, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, clr = 1'b0;
  logic        port_a_in = 1'b0, port_b_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [15:0] wdata_in = 16'h0000, d, e, cnt_a, cnt_b;
  wire  [15:0] rdata_out;
  wire         pin_a_out, pin_a_oe_out, pin_b_out, pin_b_oe_out, timer_tick_out;
  wire  [3:0]  flags_out;
  int          n_errors = 0, total_checks = 0;
  timer16_pfc_pwm DUT (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .port_a_in(port_a_in), .port_b_in(port_b_in), .pin_a_out(pin_a_out),
    .pin_a_oe_out(pin_a_oe_out), .pin_b_out(pin_b_out), .pin_b_oe_out(pin_b_oe_out),
    .timer_tick_out(timer_tick_out), .flags_out(flags_out));
  // one load on each compare pin
  pwm_load u_load_a (.clk_in(mclk_in), .pin_in(pin_a_out), .oe_in(pin_a_oe_out),
    .clr_in(clr), .high_cnt_out(cnt_a));
  pwm_load u_load_b (.clk_in(mclk_in), .pin_in(pin_b_out), .oe_in(pin_b_oe_out),
    .clr_in(clr), .high_cnt_out(cnt_b));
  ////////////////////////////////////////////////////////////////////////
  // 10 mhz clock
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  // compare and count
  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle register write
  task wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  // one-cycle register read, data taken in the following cycle
  task rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  // count high cycles on both loads over sixty cycles
  task measure(input logic [15:0] ea, input logic [15:0] eb);
    repeat (12) @(posedge mclk_in);
    clr <= 1'b1;
    @(posedge mclk_in);
    clr <= 1'b0;
    repeat (60) @(posedge mclk_in);
    #1 check(cnt_a, ea);
    check(cnt_b, eb);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reset values and control register layout
  task s_reset;
    rd_reg(8'h80, d);
    check(d, 16'h0000);
    check({12'h000, flags_out}, 16'h0000);
    rd_reg(8'h90, d);
    check(d, 16'h0000);
    wr_reg(8'h80, 16'hffff);
    rd_reg(8'h80, d);
    check(d, 16'h00f3);
    wr_reg(8'h80, 16'h0000);
  endtask
  // tick rate for every prescale select, stop included
  task automatic s_prescale;
    logic [15:0] n;
    int          dv [6] = '{1, 1, 8, 64, 256, 1024};
    for (int s = 0; s < 6; s++) begin
      wr_reg(8'h81, {11'h000, s[2:0], 2'b10});
      repeat (4) @(posedge mclk_in);
      n = 16'h0000;
      repeat (2048) begin
        @(posedge mclk_in);
        #1 n = n + {15'h0000, timer_tick_out};
      end
      check(n, s == 0 ? 16'h0000 : 16'(2048 / dv[s]));
    end
  endtask
  // read the counter every cycle and match one full dual-slope period
  task s_slope(input logic [15:0] top);
    logic [15:0] smp [0:23];
    int          k;
    k = 0;
    @(posedge mclk_in);
    addr_in <= 8'h84;
    rd_in <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      @(posedge mclk_in);
      #1 smp[i] = rdata_out;
    end
    @(posedge mclk_in);
    rd_in <= 1'b0;
    for (int i = 22; i >= 0; i--) if (smp[i] === 16'h0000 && smp[i+1] === 16'h0001) k = i;
    for (int j = 0; j <= 2 * top; j++)
      check(smp[k+j], j <= top ? 16'(j) : 16'(2 * top - j));
  endtask
  // counting, flags and top sources
  task s_count;
    wr_reg(8'h88, 16'h0003);
    wr_reg(8'h8a, 16'h0001);
    wr_reg(8'h86, 16'h0004);
    wr_reg(8'h80, 16'h0001);
    // drop flags left by earlier runs and restart the count at bottom
    wr_reg(8'h8c, 16'h000f);
    wr_reg(8'h84, 16'h0000);
    wr_reg(8'h81, 16'h0006);
    s_slope(16'h0003);
    rd_reg(8'h8c, d);
    check(d, 16'h0007);
    wr_reg(8'h8c, 16'h000f);
    wr_reg(8'h80, 16'h0000);
    s_slope(16'h0004);
    rd_reg(8'h8c, d);
    check(d & 16'h0008, 16'h0008);
    wr_reg(8'h80, 16'h0003);
    rd_reg(8'h84, d);
    rd_reg(8'h84, e);
    check(e, d);
    wr_reg(8'h80, 16'h0001);
    wr_reg(8'h8a, 16'h0005);
    repeat (20) @(posedge mclk_in);
    wr_reg(8'h8c, 16'h000f);
    repeat (20) @(posedge mclk_in);
    rd_reg(8'h8c, d);
    check(d & 16'h0004, 16'h0000);
  endtask
  // waveforms seen by the loads: polarity, extremes, toggle, port override
  task automatic s_waves;
    logic [15:0] tb [4][3] = '{'{2, 1, 20}, '{3, 1, 40}, '{2, 0, 0}, '{2, 3, 60}};
    wr_reg(8'h8d, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h8a, tb[i][1]);
      wr_reg(8'h80, {8'h00, 2'b01, tb[i][0][1:0], 4'b0001});
      measure(16'd30, tb[i][2]);
    end
    // capture as top at five: a inverted, b non-inverted, both compares three
    wr_reg(8'h86, 16'h0005);
    wr_reg(8'h80, 16'h00e0);
    measure(16'd24, 16'd36);
    @(posedge mclk_in);
    port_b_in <= 1'b1;
    wr_reg(8'h80, 16'h0011);
    measure(16'd0, 16'd60);
    wr_reg(8'h8d, 16'h0000);
    measure(16'd0, 16'd0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // print counts and verdict, then stop
  task print_verdict;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // main sequence after five reset cycles
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    s_reset;
    s_prescale;
    s_count;
    s_waves;
    print_verdict;
  end
  // watchdog, twice the expected run length
  initial begin
    #3000000;
    n_errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
